// ==== rtl/irq_ctrl_defs.svh ====
// Purpose: Offsets, field positions, reset values and vectors of the interrupt controller
// Assumes: Included by rtl/irq_vector_and_flag_control.sv and by the self-checking bench
// Notes: Register indexes are kept as printed; the bus byte address is four times the index
`ifndef IRQ_CTRL_DEFS_SVH
`define IRQ_CTRL_DEFS_SVH

// ----------------------------------------------------------------
// Register indexes and bus byte addresses
// ----------------------------------------------------------------
`define IDX_ENABLE_PENDING 12'h0C2
`define IDX_CLEAR_STROBE 12'h0C3
`define IDX_HALT_RELEASE 12'h202
`define IDX_CORE_STATUS 12'h300
`define ADDR_OF(idx) ({(idx), 2'b00})
`define AXI_ADDR_W 14

// ----------------------------------------------------------------
// Source bit positions, shared by enable, pending, clear, halt mask
// ----------------------------------------------------------------
`define BIT_KEY 1
`define BIT_PORT0 2
`define BIT_TIMER1 3
`define BIT_TIMER2 4
`define BIT_DIV1 5
`define SRC_LO 1
`define SRC_HI 5
`define SRC_MASK 8'h3E
`define MASK_RESET 8'h00
`define PENDING_RESET 8'h00
`define HALT_MASK_RESET 8'h00

// ----------------------------------------------------------------
// Vector table (low byte address) and priority levels
// ----------------------------------------------------------------
`define VEC_BREAK 16'h4000
`define VEC_DIV0 16'h4006
`define VEC_KEY 16'h4008
`define VEC_PORT0 16'h400A
`define VEC_TIMER1 16'h400C
`define VEC_TIMER2 16'h400E
`define VEC_DIV1 16'h4010
`define PRIO_BREAK 3'h2
`define PRIO_DIV0 3'h3
`define PRIO_KEY 3'h3
`define PRIO_PORT0 3'h4
`define PRIO_TIMER1 3'h5
`define PRIO_TIMER2 3'h6
`define PRIO_DIV1 3'h7
`define PRIO_NONE 3'h0

// ----------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== rtl/irq_ctrl_pkg.sv ====
// Purpose: Types shared by the interrupt controller and its bench
// Assumes: Nothing beyond the constants header
// Notes: Widths follow the 8-bit register file and 16-bit vector space
package irq_ctrl_pkg;

    typedef logic [7:0] reg8_t;
    typedef logic [15:0] vector_t;
    typedef logic [2:0] prio_t;

    // Winner of the priority selection
    typedef struct packed {
        logic valid;
        vector_t vector;
        prio_t level;
    } select_s;

endpackage : irq_ctrl_pkg

// ==== rtl/irq_vector_and_flag_control.sv ====
// Purpose: Interrupt flag latching, masking, priority and vector selection with AXI4-Lite registers
// Assumes: 20 MHz clk; event inputs other than the port pins and the divider-1 sub-status are one-cycle pulses on clk
// Notes: Registers sit at four times their index; unmapped accesses answer SLVERR
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.svh"

module irq_vector_and_flag_control
(
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Event sources
    input wire logic portZeroPin0,
    input wire logic portZeroPin4,
    input wire logic keyStrobe,
    input wire logic commonScanMode,
    input wire logic firstTimerUnderflow,
    input wire logic secondTimerUnderflow,
    input wire logic [3:0] dividerOneSubStatus,
    input wire logic dividerZeroCarry,
    // Core side
    input wire logic softwareBreak,
    input wire logic setDisableInstruction,
    input wire logic clearDisableInstruction,
    input wire logic cpuIntDisableFlag,
    input wire logic irqAccept,
    output logic irqRequest,
    output logic [15:0] irqVector,
    output logic [2:0] irqLevel,
    output logic haltWake
);
    import irq_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------

    // Word address match against a register index
    function automatic logic hitIndex(input logic [`AXI_ADDR_W-1:0] addr, input logic [11:0] idx);
        hitIndex = (addr[`AXI_ADDR_W-1:2] == idx);
    endfunction : hitIndex

    // Fixed-priority pick over requesting sources, smallest level first
    function automatic select_s pickSource(input logic software_break, input logic div0, input reg8_t act);
        pickSource.valid = 1'b1;
        pickSource.vector = `VEC_BREAK;
        pickSource.level = `PRIO_BREAK;
        if (software_break)
        begin
            pickSource.vector = `VEC_BREAK;
            pickSource.level = `PRIO_BREAK;
        end
        else if (div0)
        begin
            pickSource.vector = `VEC_DIV0;
            pickSource.level = `PRIO_DIV0;
        end
        else if (act[`BIT_KEY])
        begin
            pickSource.vector = `VEC_KEY;
            pickSource.level = `PRIO_KEY;
        end
        else if (act[`BIT_PORT0])
        begin
            pickSource.vector = `VEC_PORT0;
            pickSource.level = `PRIO_PORT0;
        end
        else if (act[`BIT_TIMER1])
        begin
            pickSource.vector = `VEC_TIMER1;
            pickSource.level = `PRIO_TIMER1;
        end
        else if (act[`BIT_TIMER2])
        begin
            pickSource.vector = `VEC_TIMER2;
            pickSource.level = `PRIO_TIMER2;
        end
        else if (act[`BIT_DIV1])
        begin
            pickSource.vector = `VEC_DIV1;
            pickSource.level = `PRIO_DIV1;
        end
        else
        begin
            pickSource.valid = 1'b0;
            pickSource.vector = `VEC_BREAK;
            pickSource.level = `PRIO_NONE;
        end
    endfunction : pickSource

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg8_t enableMask_q;
    reg8_t pending_q;
    reg8_t pending_d;
    reg8_t pendingSet;
    reg8_t pendingClr;
    reg8_t haltMask_q;
    logic block_q;
    logic [1:0] pin0Sync_q;
    logic [1:0] pin4Sync_q;
    logic pin0Last_q;
    logic pin4Last_q;
    logic divOneAny_q;
    logic divOneAny;
    logic awHeld;
    logic wHeld;
    logic [`AXI_ADDR_W-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic writeFire;
    logic writeLow;
    logic wrEnable;
    logic wrClear;
    logic wrHalt;
    logic wrStatus;
    logic writeOk;
    logic readFire;
    logic [31:0] readData;
    logic readOk;
    reg8_t activeSrc;
    logic maskableReq;
    select_s winner;

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------

    // Address and data are taken independently, in either order
    assign awHeld = ~s_axi_awready;
    assign wHeld = ~s_axi_wready;
    assign writeFire = awHeld & wHeld & ~s_axi_bvalid;
    assign writeLow = wStrb_q[0];
    assign wrEnable = writeFire & writeLow & hitIndex(awAddr_q, `IDX_ENABLE_PENDING);
    assign wrClear = writeFire & writeLow & hitIndex(awAddr_q, `IDX_CLEAR_STROBE);
    assign wrHalt = writeFire & writeLow & hitIndex(awAddr_q, `IDX_HALT_RELEASE);
    assign wrStatus = writeFire & writeLow & hitIndex(awAddr_q, `IDX_CORE_STATUS);
    assign writeOk = hitIndex(awAddr_q, `IDX_ENABLE_PENDING) | hitIndex(awAddr_q, `IDX_CLEAR_STROBE)
        | hitIndex(awAddr_q, `IDX_HALT_RELEASE) | hitIndex(awAddr_q, `IDX_CORE_STATUS);

    // Write address acceptance; reopens once the response is taken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            awAddr_q <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            s_axi_awready <= 1'b0;
            awAddr_q <= s_axi_awaddr;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_awready <= 1'b1;
        end
    end

    // Write data acceptance
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_wready <= 1'b1;
            wData_q <= '0;
            wStrb_q <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            s_axi_wready <= 1'b0;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write response, one cycle after both halves are held
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else if (writeFire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeOk ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    assign readFire = s_axi_arvalid & s_axi_arready;

    // Read mux; the enable/pending address returns the flags, not the mask
    always_comb
    begin
        readData = '0;
        readOk = 1'b1;
        if (hitIndex(s_axi_araddr, `IDX_ENABLE_PENDING))
        begin
            readData[7:0] = pending_q & `SRC_MASK;
        end
        else if (hitIndex(s_axi_araddr, `IDX_HALT_RELEASE))
        begin
            readData[7:0] = haltMask_q;
        end
        else if (hitIndex(s_axi_araddr, `IDX_CORE_STATUS))
        begin
            readData = {6'h00, irqRequest, block_q, 5'h00, irqLevel, irqVector};
        end
        else if (hitIndex(s_axi_araddr, `IDX_CLEAR_STROBE))
        begin
            readData = '0; // Strobe register reads as zero
        end
        else
        begin
            readOk = 1'b0;
        end
    end

    // Read address acceptance and data return, one item in flight
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (readFire)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readData;
            s_axi_rresp <= readOk ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------

    // Enable mask, write-only; unused bits never stick
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enableMask_q <= `MASK_RESET;
        end
        else if (wrEnable)
        begin
            enableMask_q <= wData_q[7:0] & `SRC_MASK;
        end
    end

    // Halt-release mask, same layout as the enable mask
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            haltMask_q <= `HALT_MASK_RESET;
        end
        else if (wrHalt)
        begin
            haltMask_q <= wData_q[7:0] & `SRC_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------

    // Port pins are asynchronous: two flops before anything looks at them
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin0Sync_q <= 2'b00;
            pin4Sync_q <= 2'b00;
            pin0Last_q <= 1'b0;
            pin4Last_q <= 1'b0;
        end
        else
        begin
            pin0Sync_q <= {pin0Sync_q[0], portZeroPin0};
            pin4Sync_q <= {pin4Sync_q[0], portZeroPin4};
            pin0Last_q <= pin0Sync_q[1];
            pin4Last_q <= pin4Sync_q[1];
        end
    end

    // Divider-1 sub-flags fold into one level; the flag sets on its rise,
    // so it re-arms only after every sub-flag has been cleared as well
    assign divOneAny = |dividerOneSubStatus;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divOneAny_q <= 1'b0;
        end
        else
        begin
            divOneAny_q <= divOneAny;
        end
    end

    // Set terms per source
    always_comb
    begin
        pendingSet = '0;
        pendingSet[`BIT_KEY] = keyStrobe & commonScanMode;
        pendingSet[`BIT_PORT0] = (pin0Sync_q[1] ^ pin0Last_q) | (pin4Sync_q[1] ^ pin4Last_q);
        pendingSet[`BIT_TIMER1] = firstTimerUnderflow;
        pendingSet[`BIT_TIMER2] = secondTimerUnderflow;
        pendingSet[`BIT_DIV1] = divOneAny & ~divOneAny_q;
    end

    // ----------------------------------------------------------------
    // Pending flags
    // ----------------------------------------------------------------

    // Clear only by a one in the strobe write; acceptance never clears
    assign pendingClr = wrClear ? (wData_q[7:0] & `SRC_MASK) : 8'h00;

    // Set beats clear so an event landing on a clear is kept
    assign pending_d = ((pending_q & ~pendingClr) | pendingSet) & `SRC_MASK;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_q <= `PENDING_RESET;
        end
        else
        begin
            pending_q <= pending_d;
        end
    end

    // ----------------------------------------------------------------
    // Blocking after acceptance
    // ----------------------------------------------------------------

    // Acceptance and set-disable block; clear-disable, an enable-mask write or a status write
    // with bit 0 set re-opens. A same-cycle block request wins so nothing slips through.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            block_q <= 1'b0;
        end
        else if (irqAccept || setDisableInstruction)
        begin
            block_q <= 1'b1;
        end
        else if (clearDisableInstruction || wrEnable || (wrStatus && wData_q[0]))
        begin
            block_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Request, vector and wake outputs
    // ----------------------------------------------------------------
    assign activeSrc = pending_q & enableMask_q;
    assign maskableReq = (|activeSrc) & ~block_q & ~cpuIntDisableFlag;
    assign winner = pickSource(softwareBreak & ~block_q, dividerZeroCarry & ~block_q,
        maskableReq ? activeSrc : 8'h00);

    // Registered request; break and divider-0 bypass the mask but not the block
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irqRequest <= 1'b0;
        end
        else
        begin
            irqRequest <= maskableReq | ((softwareBreak | dividerZeroCarry) & ~block_q);
        end
    end

    // Vector of the winner; holds the last value when nothing requests
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irqVector <= `VEC_BREAK;
            irqLevel <= `PRIO_NONE;
        end
        else
        begin
            irqVector <= winner.valid ? winner.vector : irqVector;
            irqLevel <= winner.level;
        end
    end

    // Any enabled wake source pending releases halt, independent of blocking
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            haltWake <= 1'b0;
        end
        else
        begin
            haltWake <= |(pending_q & haltMask_q);
        end
    end

endmodule : irq_vector_and_flag_control
`default_nettype wire

// ==== tb/irq_ctrl_properties.sv ====
// Purpose: Port-level assertions for the interrupt controller
// Assumes: Bound to the top module; one clock domain
// Notes: Latencies follow the one-cycle flop outputs of the block
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_properties
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic setDisableInstruction,
    input wire logic cpuIntDisableFlag,
    input wire logic irqAccept,
    input wire logic irqRequest,
    input wire logic [15:0] irqVector,
    input wire logic [2:0] irqLevel
);
    // ----
    // Register bus
    // ----
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write answer missing");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
        else $error("read answer missing or wide");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");

    // ----
    // Request path
    // ----
    a_accept_blocks: assert property (irqAccept |-> ##2 !irqRequest)
        else $error("request not blocked after accept");
    a_set_disable: assert property (setDisableInstruction |-> ##2 !irqRequest)
        else $error("request not blocked after set-disable");
    a_disable_flag: assert property (cpuIntDisableFlag && $past(cpuIntDisableFlag) |->
        !irqRequest || irqLevel <= 3'h3)
        else $error("maskable request while core disabled");
    a_level_none: assert property (!irqRequest |-> irqLevel == 3'h0)
        else $error("level without request");
    a_vector_table: assert property (irqRequest |->
        (irqLevel == 3'h2 && irqVector == 16'h4000)
        || (irqLevel == 3'h3 && (irqVector == 16'h4006 || irqVector == 16'h4008))
        || (irqLevel == 3'h4 && irqVector == 16'h400A) || (irqLevel == 3'h5 && irqVector == 16'h400C)
        || (irqLevel == 3'h6 && irqVector == 16'h400E) || (irqLevel == 3'h7 && irqVector == 16'h4010))
        else $error("vector and level disagree");
endmodule : irq_ctrl_properties
`default_nettype wire

// ==== tb/irq_core_model.sv ====
// Purpose: Core model that accepts interrupt requests
// Assumes: Accepts only while autoAck is high
// Notes: One accept per request; waits ackDelay cycles, so prompt and slow cores are both possible
`timescale 1ns/1ps
`default_nettype none
module irq_core_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irqRequest,
    input wire logic autoAck,
    input wire logic [3:0] ackDelay,
    output logic irqAccept
);
    logic [3:0] waitCount;
    logic served;

    // Count the wait, pulse accept once, re-arm only after the request drops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitCount <= 4'h0;
            served <= 1'h0;
            irqAccept <= 1'h0;
        end
        else
        begin
            irqAccept <= 1'h0;
            if (!irqRequest)
            begin
                waitCount <= 4'h0;
                served <= 1'h0;
            end
            else if (autoAck && !served && waitCount == ackDelay)
            begin
                irqAccept <= 1'h1;
                served <= 1'h1;
            end
            else if (autoAck && !served)
                waitCount <= waitCount + 4'h1;
        end
    end
endmodule : irq_core_model
`default_nettype wire

// ==== tb/test_irq_vector_and_flag_control.sv ====
// Purpose: Self-checking bench of the interrupt controller
// Assumes: bready and rready held high, so every answer is taken at once
// Notes: Fixed waits cover the one-cycle flag and request latencies; pins need two more
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.svh"
module test_irq_vector_and_flag_control;
    import irq_ctrl_pkg::*;
    localparam logic [13:0] A_FLAGS = `ADDR_OF(12'h0C2);
    localparam logic [13:0] A_CLR = `ADDR_OF(12'h0C3);
    localparam logic [13:0] A_HALT = `ADDR_OF(12'h202);
    localparam logic [13:0] A_BAD = `ADDR_OF(12'h0C4);
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, dividerOneSubStatus = 4'h0, ackDelay = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irqAccept, irqRequest, haltWake;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic portZeroPin0 = 1'h0, portZeroPin4 = 1'h0, keyStrobe = 1'h0, commonScanMode = 1'h0, autoAck = 1'h0;
    logic firstTimerUnderflow = 1'h0, secondTimerUnderflow = 1'h0, dividerZeroCarry = 1'h0, softwareBreak = 1'h0;
    logic setDisableInstruction = 1'h0, clearDisableInstruction = 1'h0, cpuIntDisableFlag = 1'h0;
    logic [15:0] irqVector;
    logic [2:0] irqLevel;
    int fail_count = 0;
    int check_count = 0;

    irq_vector_and_flag_control i_irq_vector_and_flag_control (.*);
    irq_core_model i_irq_core_model (.clk(clk), .rst_n(rst_n), .irqRequest(irqRequest), .autoAck(autoAck),
        .ackDelay(ackDelay), .irqAccept(irqAccept));

    // ----
    // Clock and helpers
    // ----
    always #25 clk = ~clk;

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic irq_is(input logic r, input logic [15:0] v, input logic [2:0] l);
        chk("irqRequest", r, irqRequest);
        chk("irqLevel", l, irqLevel);
        if (r)
            chk("irqVector", v, irqVector);
    endtask : irq_is

    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready === 1'h1)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1)
                s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1);
        chk("bresp", er, s_axi_bresp);
    endtask : axi_wr

    task automatic axi_rd(input logic [13:0] a, input logic [7:0] ed, input logic [1:0] er, input string nm);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1);
        chk(nm, {24'h000000, ed}, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask : axi_rd

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // Watchdog: the tests need well under two thousand cycles
    initial
    begin
        step(20000);
        fail_count++;
        report_and_stop();
    end

    // ----
    // Tests
    // ----
    initial
    begin
        step(20);
        rst_n <= 1'h1;
        step(1);
        irq_is(1'h0, 16'h0000, 3'h0);
        axi_rd(A_FLAGS, 8'h00, 2'h0, "pending");
        axi_rd(A_CLR, 8'h00, 2'h0, "clear reg");
        axi_rd(A_BAD, 8'h00, 2'h2, "unmapped");
        axi_wr(A_BAD, 8'hFF, 2'h2);
        $display("test reset done");
        // Timer 1 taken, blocked, unblocked by a mask write, then cleared
        axi_wr(A_FLAGS, 8'h08, 2'h0);
        firstTimerUnderflow <= 1'h1;
        step(1);
        firstTimerUnderflow <= 1'h0;
        step(3);
        irq_is(1'h1, 16'h400C, 3'h5);
        ackDelay <= 4'h3;
        autoAck <= 1'h1;
        step(8);
        autoAck <= 1'h0;
        irq_is(1'h0, 16'h0000, 3'h0);
        axi_rd(A_FLAGS, 8'h08, 2'h0, "pending kept");
        axi_wr(A_FLAGS, 8'h08, 2'h0);
        step(3);
        irq_is(1'h1, 16'h400C, 3'h5);
        axi_wr(A_CLR, 8'h08, 2'h0);
        step(2);
        irq_is(1'h0, 16'h0000, 3'h0);
        $display("test timer done");
        // Masked latching, key only in scan mode, priority order
        axi_wr(A_FLAGS, 8'h00, 2'h0);
        secondTimerUnderflow <= 1'h1;
        keyStrobe <= 1'h1;
        step(1);
        secondTimerUnderflow <= 1'h0;
        keyStrobe <= 1'h0;
        step(3);
        irq_is(1'h0, 16'h0000, 3'h0);
        axi_rd(A_FLAGS, 8'h10, 2'h0, "masked pending");
        commonScanMode <= 1'h1;
        keyStrobe <= 1'h1;
        step(1);
        keyStrobe <= 1'h0;
        axi_wr(A_FLAGS, 8'h12, 2'h0);
        step(2);
        irq_is(1'h1, 16'h4008, 3'h3);
        axi_wr(A_CLR, 8'h02, 2'h0);
        step(2);
        irq_is(1'h1, 16'h400E, 3'h6);
        $display("test priority done");
        // Port edges: pin 0 rise, pin 4 rise, pin 4 fall; halt wake
        axi_wr(A_FLAGS, 8'h04, 2'h0);
        for (int i = 0; i < 3; i++)
        begin
            axi_wr(A_CLR, 8'h3E, 2'h0);
            axi_rd(A_FLAGS, 8'h00, 2'h0, "flags cleared");
            if (i == 0)
                portZeroPin0 <= 1'h1;
            else
                portZeroPin4 <= (i == 1);
            step(6);
            irq_is(1'h1, 16'h400A, 3'h4);
        end
        axi_wr(A_HALT, 8'h04, 2'h0);
        step(2);
        chk("haltWake", 1'h1, haltWake);
        axi_rd(A_HALT, 8'h04, 2'h0, "halt mask");
        $display("test port done");
        // Divider-1: OR of sub-status, re-arm only after sub-status clears
        axi_wr(A_FLAGS, 8'h20, 2'h0);
        axi_wr(A_CLR, 8'h3E, 2'h0);
        dividerOneSubStatus <= 4'h2;
        step(3);
        irq_is(1'h1, 16'h4010, 3'h7);
        axi_wr(A_CLR, 8'h20, 2'h0);
        step(3);
        irq_is(1'h0, 16'h0000, 3'h0);
        dividerOneSubStatus <= 4'h0;
        step(2);
        dividerOneSubStatus <= 4'h8;
        step(3);
        irq_is(1'h1, 16'h4010, 3'h7);
        $display("test divider done");
        // Core disable flag, break and divider-0, set and clear disable
        cpuIntDisableFlag <= 1'h1;
        step(3);
        irq_is(1'h0, 16'h0000, 3'h0);
        softwareBreak <= 1'h1;
        step(3);
        irq_is(1'h1, 16'h4000, 3'h2);
        softwareBreak <= 1'h0;
        dividerZeroCarry <= 1'h1;
        step(3);
        irq_is(1'h1, 16'h4006, 3'h3);
        dividerZeroCarry <= 1'h0;
        cpuIntDisableFlag <= 1'h0;
        step(3);
        irq_is(1'h1, 16'h4010, 3'h7);
        setDisableInstruction <= 1'h1;
        step(1);
        setDisableInstruction <= 1'h0;
        step(3);
        irq_is(1'h0, 16'h0000, 3'h0);
        clearDisableInstruction <= 1'h1;
        step(1);
        clearDisableInstruction <= 1'h0;
        step(3);
        irq_is(1'h1, 16'h4010, 3'h7);
        $display("test core gating done");
        report_and_stop();
    end
endmodule : test_irq_vector_and_flag_control

bind irq_vector_and_flag_control irq_ctrl_properties i_irq_ctrl_properties (.*);
`default_nettype wire
